/* File: hw/tpwm_pkg.sv */
// package: register map, field layout, mode codes and helper functions of the pwm timer
package tpwm_pkg;
    // register byte offsets on the apb bus
    localparam logic [7:0]  ADDR_CTRL   = 8'h00;
    localparam logic [7:0]  ADDR_CNT    = 8'h04;
    localparam logic [7:0]  ADDR_CMPA   = 8'h08;
    localparam logic [7:0]  ADDR_CMPB   = 8'h0C;
    localparam logic [7:0]  ADDR_CAPTOP = 8'h10;
    localparam logic [7:0]  ADDR_FLAGS  = 8'h14;
    // control register fields
    localparam int          CTRL_MODE_LSB = 0;
    localparam int          CTRL_ACTA_LSB = 4;
    localparam int          CTRL_ACTB_LSB = 6;
    localparam int          CTRL_CLK_LSB  = 8;
    localparam int          CTRL_DIRA_BIT = 11;
    localparam int          CTRL_DIRB_BIT = 12;
    localparam logic [12:0] CTRL_RESET    = 13'h0000;
    // flag register bits
    localparam int          FLAG_OVF  = 0;
    localparam int          FLAG_CMPA = 1;
    localparam int          FLAG_CMPB = 2;
    localparam int          FLAG_CAP  = 3;
    localparam logic [3:0]  FLAGS_RESET = 4'h0;
    // counter landmarks
    localparam logic [15:0] CNT_BOTTOM = 16'h0000;
    localparam logic [15:0] CNT_ONE    = 16'h0001;
    localparam logic [15:0] CNT_MAX    = 16'hFFFF;
    localparam logic [15:0] TOP_8BIT   = 16'h00FF;
    localparam logic [15:0] TOP_9BIT   = 16'h01FF;
    localparam logic [15:0] TOP_10BIT  = 16'h03FF;
    // waveform_mode_select codes handled here
    localparam logic [3:0]  MODE_PC8     = 4'h1;
    localparam logic [3:0]  MODE_PC9     = 4'h2;
    localparam logic [3:0]  MODE_PC10    = 4'h3;
    localparam logic [3:0]  MODE_FP8     = 4'h5;
    localparam logic [3:0]  MODE_FP9     = 4'h6;
    localparam logic [3:0]  MODE_FP10    = 4'h7;
    localparam logic [3:0]  MODE_PC_CAP  = 4'hA;
    localparam logic [3:0]  MODE_PC_CMPA = 4'hB;
    localparam logic [3:0]  MODE_FP_CAP  = 4'hE;
    localparam logic [3:0]  MODE_FP_CMPA = 4'hF;
    // output_action_select codes
    localparam logic [1:0]  ACT_OFF    = 2'h0;
    localparam logic [1:0]  ACT_TOGGLE = 2'h1;
    localparam logic [1:0]  ACT_NONINV = 2'h2;
    localparam logic [1:0]  ACT_INV    = 2'h3;
    // prescaler: select code 0 stops, 1..5 divide by 1, 8, 64, 256, 1024
    localparam logic [2:0]  CLKSEL_STOP = 3'h0;
    localparam logic [9:0]  DIV1_LAST    = 10'h000;
    localparam logic [9:0]  DIV8_LAST    = 10'h007;
    localparam logic [9:0]  DIV64_LAST   = 10'h03F;
    localparam logic [9:0]  DIV256_LAST  = 10'h0FF;
    localparam logic [9:0]  DIV1024_LAST = 10'h3FF;

    typedef enum logic [1:0] {TPWM_SLOPE_PLAIN, TPWM_SLOPE_SINGLE, TPWM_SLOPE_DUAL} tpwm_slope_t;

    // counting style of a waveform mode
    function automatic tpwm_slope_t slope_of(input logic [3:0] mode);
        case (mode)
            MODE_PC8, MODE_PC9, MODE_PC10, MODE_PC_CAP, MODE_PC_CMPA: slope_of = TPWM_SLOPE_DUAL;
            MODE_FP8, MODE_FP9, MODE_FP10, MODE_FP_CAP, MODE_FP_CMPA: slope_of = TPWM_SLOPE_SINGLE;
            default: slope_of = TPWM_SLOPE_PLAIN;
        endcase
    endfunction : slope_of

    // top of the count; with both sources at max it is the fixed-resolution mask
    function automatic logic [15:0] top_of(input logic [3:0]  mode,
                                           input logic [15:0] captop,
                                           input logic [15:0] cmpa);
        case (mode)
            MODE_PC8, MODE_FP8:          top_of = TOP_8BIT;
            MODE_PC9, MODE_FP9:          top_of = TOP_9BIT;
            MODE_PC10, MODE_FP10:        top_of = TOP_10BIT;
            MODE_PC_CAP, MODE_FP_CAP:    top_of = captop;
            MODE_PC_CMPA, MODE_FP_CMPA:  top_of = cmpa;
            default:                     top_of = CNT_MAX;
        endcase
    endfunction : top_of

    // last prescaler count before a timer tick
    function automatic logic [9:0] div_last(input logic [2:0] sel);
        case (sel)
            3'h2:    div_last = DIV8_LAST;
            3'h3:    div_last = DIV64_LAST;
            3'h4:    div_last = DIV256_LAST;
            3'h5:    div_last = DIV1024_LAST;
            default: div_last = DIV1_LAST;
        endcase
    endfunction : div_last
endpackage : tpwm_pkg

/* File: hw/tpwm_prescale.sv */
// prescaler: timer clock enable derived from the i/o clock
`timescale 1ns/100ps
module tpwm_prescale import tpwm_pkg::*; (
    input  wire logic       clk,
    input  wire logic       rstn,
    input  wire logic [2:0] clk_sel,
    output logic            tick_q
);
    typedef struct packed {
        logic [9:0] count;
        logic       tick;
    } tpwm_pre_t;

    tpwm_pre_t s_q;
    tpwm_pre_t s_d;

    // >= rather than == so a shorter divider never strands the count
    always_comb begin
        s_d      = s_q;
        s_d.tick = 1'b0;
        if (clk_sel == CLKSEL_STOP) begin
            s_d.count = '0;
        end else if (s_q.count >= div_last(clk_sel)) begin
            s_d.count = '0;
            s_d.tick  = 1'b1;
        end else begin
            s_d.count = s_q.count + 10'h001;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign tick_q = s_q.tick;
endmodule : tpwm_prescale

/* File: hw/tpwm_chan.sv */
// compare channel: buffered compare value and waveform output level
`timescale 1ns/100ps
module tpwm_chan import tpwm_pkg::*; (
    input  wire logic        clk,
    input  wire logic        rstn,
    input  wire logic        wr_en,
    input  wire logic [15:0] wr_data,
    input  wire logic        load,
    input  wire logic        tick,
    input  wire logic [15:0] cnt,
    input  wire logic        fast,
    input  wire logic        dual,
    input  wire logic        match_up,
    input  wire logic        at_top,
    input  wire logic        toggle_ok,
    input  wire logic [1:0]  act,
    output logic [15:0]      buf_q,
    output logic [15:0]      cmp_q,
    output logic             level_q
);
    typedef struct packed {
        logic [15:0] buffer;
        logic [15:0] cmp;
        logic        level;
    } tpwm_chan_t;

    tpwm_chan_t s_q;
    tpwm_chan_t s_d;
    logic       match;

    // buffer takes writes at any time, active value only on load
    always_comb begin
        s_d   = s_q;
        match = tick && (cnt == s_q.cmp);
        if (wr_en) begin
            s_d.buffer = wr_data;
        end
        if (load) begin
            s_d.cmp = s_d.buffer;
        end
        if (match && (fast || dual)) begin
            case (act)
                ACT_TOGGLE: if (toggle_ok) s_d.level = ~s_q.level;
                ACT_NONINV: s_d.level = dual ? ~match_up : 1'b0;
                ACT_INV:    s_d.level = dual ? match_up : 1'b1;
                default:    ;
            endcase
        end
        // top-to-bottom action overrides a match at top, so compare==top is flat
        if (fast && tick && at_top) begin
            if (act == ACT_NONINV) begin
                s_d.level = 1'b1;
            end else if (act == ACT_INV) begin
                s_d.level = 1'b0;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign buf_q   = s_q.buffer;
    assign cmp_q   = s_q.cmp;
    assign level_q = s_q.level;
endmodule : tpwm_chan

/* File: hw/tpwm_timer.sv */
// 16-bit pwm timer: fast and phase correct modes behind an apb slave
// Operation
// - in fixed-top modes, compare writes clear bits above the resolution
// - capture/top is unbuffered; set below count, counter wraps through 0xFFFF first
// - compare A writes go to a buffer, loaded at top in fast pwm
// - fast pwm output changes on match and reverts when count wraps to bottom
// - fast pwm action two and three give opposite polarities
// - output level reaches the pin only when its direction bit selects output
// - fast pwm period is prescaler times top plus one i/o clocks
// - fast pwm compare zero gives a spike, compare at top is flat
// - fast pwm mode 15 with toggle action gives 50% square wave on A
// - phase correct modes 1,2,3,10,11 count up to top and back down
// - phase correct tops: 0x00FF, 0x01FF, 0x03FF, capture/top, compare A
// - phase correct counter does not hold top; the tick at top already counts down
// - a compare match sets that channel's compare flag
// - phase correct overflow flag sets when the counter reaches bottom
// - phase correct loads compares at top; top-source flag sets then
// - phase correct action two clears on up match, sets on down match
// - phase correct period is twice prescaler times top i/o clocks
// - phase correct compare at bottom is flat low, at top flat high
// - phase correct mode 11 with toggle action gives 50% square wave on A
// - fast pwm tops: 0x00FF, 0x01FF, 0x03FF, capture/top, compare A; clear after top
// - fast pwm overflow flag sets at top, with the top-source flag
`timescale 1ns/100ps
module tpwm_timer import tpwm_pkg::*; (
    input  wire logic        clk,
    input  wire logic        rstn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             pin_a_out,
    output logic             pin_a_oe,
    output logic             pin_b_out,
    output logic             pin_b_oe
);
    typedef struct packed {
        logic [12:0] ctrl;
        logic [15:0] cnt;
        logic        up;
        logic [15:0] captop;
        logic [3:0]  flags;
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
        logic        pin_a_out;
        logic        pin_a_oe;
        logic        pin_b_out;
        logic        pin_b_oe;
    } tpwm_state_t;

    tpwm_state_t s_q;
    tpwm_state_t s_d;

    logic        tick;
    logic [3:0]  mode;
    logic [1:0]  act_a;
    logic [1:0]  act_b;
    tpwm_slope_t slope;
    logic        fast;
    logic        dual;
    logic [15:0] top;
    logic [15:0] wmask;
    logic        at_top;
    logic        upd;
    logic        ld;
    logic        match_up;
    logic        toggle_ok;
    logic        commit;
    logic        wr_ctrl;
    logic        wr_cnt;
    logic        wr_cmpa;
    logic        wr_cmpb;
    logic        wr_cap;
    logic        wr_flags;
    logic        match_a;
    logic        match_b;
    logic        addr_ok;
    logic [3:0]  flag_set;
    logic [15:0] bufa_q;
    logic [15:0] bufb_q;
    logic [15:0] cmpa_q;
    logic [15:0] cmpb_q;
    logic        level_a;
    logic        level_b;
    logic [15:0] wdata16;

    // timer clock enable; the i/o clock itself never stops
    tpwm_prescale u_prescale (
        .clk     (clk),
        .rstn    (rstn),
        .clk_sel (s_q.ctrl[CTRL_CLK_LSB +: 3]),
        .tick_q  (tick)
    );

    // mode decode and counter landmarks
    always_comb begin
        mode      = s_q.ctrl[CTRL_MODE_LSB +: 4];
        act_a     = s_q.ctrl[CTRL_ACTA_LSB +: 2];
        act_b     = s_q.ctrl[CTRL_ACTB_LSB +: 2];
        slope     = slope_of(mode);
        fast      = (slope == TPWM_SLOPE_SINGLE);
        dual      = (slope == TPWM_SLOPE_DUAL);
        top       = top_of(mode, s_q.captop, cmpa_q);
        wmask     = top_of(mode, CNT_MAX, CNT_MAX);
        at_top    = (s_q.cnt == top);
        upd       = tick && at_top && (fast || dual);
        ld        = (fast || dual) ? upd : 1'b1;
        // bottom counts as rising and top as falling, giving flat extremes
        match_up  = (s_q.cnt == CNT_BOTTOM) ? 1'b1 : (at_top ? 1'b0 : s_q.up);
        toggle_ok = (mode == MODE_FP_CMPA) || (mode == MODE_PC_CMPA);
        match_a   = tick && (s_q.cnt == cmpa_q);
        match_b   = tick && (s_q.cnt == cmpb_q);
    end

    // apb decode: a write lands at the edge where pready is seen high
    always_comb begin
        commit   = psel && penable && s_q.pready;
        wr_ctrl  = commit && pwrite && (paddr == ADDR_CTRL);
        wr_cnt   = commit && pwrite && (paddr == ADDR_CNT);
        wr_cmpa  = commit && pwrite && (paddr == ADDR_CMPA);
        wr_cmpb  = commit && pwrite && (paddr == ADDR_CMPB);
        wr_cap   = commit && pwrite && (paddr == ADDR_CAPTOP);
        wr_flags = commit && pwrite && (paddr == ADDR_FLAGS);
        addr_ok  = (paddr == ADDR_CTRL) || (paddr == ADDR_CNT) || (paddr == ADDR_CMPA) ||
                   (paddr == ADDR_CMPB) || (paddr == ADDR_CAPTOP) || (paddr == ADDR_FLAGS);
        wdata16  = pwdata[15:0] & wmask;
    end

    // compare channels A and B
    tpwm_chan u_chan_a (
        .clk       (clk),
        .rstn      (rstn),
        .wr_en     (wr_cmpa),
        .wr_data   (wdata16),
        .load      (ld),
        .tick      (tick),
        .cnt       (s_q.cnt),
        .fast      (fast),
        .dual      (dual),
        .match_up  (match_up),
        .at_top    (at_top),
        .toggle_ok (toggle_ok),
        .act       (act_a),
        .buf_q     (bufa_q),
        .cmp_q     (cmpa_q),
        .level_q   (level_a)
    );

    tpwm_chan u_chan_b (
        .clk       (clk),
        .rstn      (rstn),
        .wr_en     (wr_cmpb),
        .wr_data   (wdata16),
        .load      (ld),
        .tick      (tick),
        .cnt       (s_q.cnt),
        .fast      (fast),
        .dual      (dual),
        .match_up  (match_up),
        .at_top    (at_top),
        .toggle_ok (1'b0),
        .act       (act_b),
        .buf_q     (bufb_q),
        .cmp_q     (cmpb_q),
        .level_q   (level_b)
    );

    // flag sources; other modes count plainly and overflow at max
    always_comb begin
        flag_set = 4'h0;
        if (tick) begin
            if (fast) begin
                flag_set[FLAG_OVF] = at_top;
            end else if (dual) begin
                flag_set[FLAG_OVF] = (s_q.cnt == CNT_BOTTOM) && !s_q.up;
            end else begin
                flag_set[FLAG_OVF] = (s_q.cnt == CNT_MAX);
            end
        end
        flag_set[FLAG_CMPA] = match_a || (upd && toggle_ok);
        flag_set[FLAG_CMPB] = match_b;
        flag_set[FLAG_CAP]  = upd && ((mode == MODE_PC_CAP) || (mode == MODE_FP_CAP));
    end

    // next state: counter, registers, bus answer and pins
    always_comb begin
        s_d = s_q;
        if (tick) begin
            if (dual) begin
                if (s_q.up) begin
                    if (at_top) begin
                        s_d.up  = 1'b0;
                        s_d.cnt = s_q.cnt - CNT_ONE;
                    end else begin
                        s_d.cnt = s_q.cnt + CNT_ONE;
                    end
                end else if (s_q.cnt == CNT_BOTTOM) begin
                    s_d.up  = 1'b1;
                    s_d.cnt = s_q.cnt + CNT_ONE;
                end else begin
                    s_d.cnt = s_q.cnt - CNT_ONE;
                end
            end else if (fast && at_top) begin
                s_d.cnt = CNT_BOTTOM;
            end else begin
                s_d.cnt = s_q.cnt + CNT_ONE;
            end
        end
        if (!dual) begin
            s_d.up = 1'b1;
        end
        // a software write to the counter beats the tick
        if (wr_cnt) begin
            s_d.cnt = pwdata[15:0];
        end
        if (wr_ctrl) begin
            s_d.ctrl = pwdata[12:0];
        end
        if (wr_cap) begin
            s_d.captop = pwdata[15:0];
        end
        // write-one-to-clear, a same-cycle set wins
        s_d.flags = (s_q.flags & ~(wr_flags ? pwdata[3:0] : 4'h0)) | flag_set;
        // one wait state so read data comes from a flop
        s_d.pready  = psel && penable && !s_q.pready;
        s_d.pslverr = 1'b0;
        s_d.prdata  = 32'h0000_0000;
        if (psel && penable && !s_q.pready) begin
            s_d.pslverr = !addr_ok;
            case (paddr)
                ADDR_CTRL:   s_d.prdata = {19'h0_0000, s_q.ctrl};
                ADDR_CNT:    s_d.prdata = {16'h0000, s_q.cnt};
                ADDR_CMPA:   s_d.prdata = {16'h0000, bufa_q};
                ADDR_CMPB:   s_d.prdata = {16'h0000, bufb_q};
                ADDR_CAPTOP: s_d.prdata = {16'h0000, s_q.captop};
                ADDR_FLAGS:  s_d.prdata = {28'h000_0000, s_q.flags};
                default:     s_d.prdata = 32'h0000_0000;
            endcase
        end
        // the pin shows the level only while its direction bit drives it
        s_d.pin_a_oe  = s_q.ctrl[CTRL_DIRA_BIT];
        s_d.pin_a_out = level_a && s_q.ctrl[CTRL_DIRA_BIT];
        s_d.pin_b_oe  = s_q.ctrl[CTRL_DIRB_BIT];
        s_d.pin_b_out = level_b && s_q.ctrl[CTRL_DIRB_BIT];
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            s_q        <= '0;
            s_q.ctrl   <= CTRL_RESET;
            s_q.cnt    <= CNT_BOTTOM;
            s_q.up     <= 1'b1;
            s_q.flags  <= FLAGS_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    assign prdata    = s_q.prdata;
    assign pready    = s_q.pready;
    assign pslverr   = s_q.pslverr;
    assign pin_a_out = s_q.pin_a_out;
    assign pin_a_oe  = s_q.pin_a_oe;
    assign pin_b_out = s_q.pin_b_out;
    assign pin_b_oe  = s_q.pin_b_oe;

    // checks on counter, flags, compare buffering and pins
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    a_fast_wrap_zero: assert property (fast && tick && at_top && !wr_cnt |=> s_q.cnt == CNT_BOTTOM)
        else $error("fast pwm counter did not clear after top");

    a_wrap_past_max: assert property (
        !dual && tick && s_q.cnt == CNT_MAX && !at_top && !wr_cnt |=> s_q.cnt == CNT_BOTTOM)
        else $error("counter did not wrap from max to bottom");

    a_phase_top_turn: assert property (
        dual && tick && s_q.up && at_top && !wr_cnt && !wr_ctrl
        |=> !s_q.up && s_q.cnt == $past(s_q.cnt) - CNT_ONE)
        else $error("phase correct counter did not turn down after top");

    a_fast_ovf_flag: assert property (fast && tick && at_top |=> s_q.flags[FLAG_OVF])
        else $error("overflow flag missing at fast pwm top");

    a_phase_ovf_flag: assert property (
        dual && tick && !s_q.up && s_q.cnt == CNT_BOTTOM |=> s_q.flags[FLAG_OVF])
        else $error("overflow flag missing at phase correct bottom");

    a_cmpa_match_flag: assert property (match_a |=> s_q.flags[FLAG_CMPA])
        else $error("compare A flag missing after match");

    a_cmpb_match_flag: assert property (match_b |=> s_q.flags[FLAG_CMPB])
        else $error("compare B flag missing after match");

    a_cap_top_flag: assert property (upd && mode == MODE_PC_CAP |=> s_q.flags[FLAG_CAP])
        else $error("capture flag missing at top");

    a_cmpa_buf_load: assert property (upd && !wr_cmpa |=> cmpa_q == $past(bufa_q))
        else $error("compare A not loaded from buffer at top");

    a_cmpa_hold_off: assert property ((fast || dual) && !upd && !wr_ctrl |=> $stable(cmpa_q))
        else $error("compare A changed away from top");

    a_mask_fixed: assert property (wr_cmpa && mode == MODE_FP8 |=> bufa_q[15:8] == 8'h00)
        else $error("fixed top write kept upper compare bits");

    // pin is held against its own enable, so a direction write in flight cannot fire it
    a_fast_set_top: assert property (
        fast && tick && at_top && act_a == ACT_NONINV && !wr_ctrl
        |=> level_a ##1 pin_a_out == pin_a_oe)
        else $error("fast pwm output A not set at bottom");

    a_fast_clear_match: assert property (
        fast && match_a && !at_top && act_a == ACT_NONINV |=> !level_a)
        else $error("fast pwm output A not cleared on match");

    a_phase_up_clear: assert property (
        dual && match_a && match_up && act_a == ACT_NONINV |=> !level_a)
        else $error("phase correct output A not cleared on up match");

    a_phase_down_set: assert property (
        dual && match_a && !match_up && act_a == ACT_NONINV |=> level_a)
        else $error("phase correct output A not set on down match");

    a_pin_gate: assert property (!pin_a_oe |-> !pin_a_out)
        else $error("pin A driven level while direction is input");

    c_fast_wrap: cover property (fast && tick && at_top ##1 s_q.cnt == CNT_BOTTOM);
    c_phase_turn: cover property (dual && tick && !s_q.up && s_q.cnt == CNT_BOTTOM);
    c_apb_write: cover property (psel && penable && pwrite && pready);
    c_toggle_a: cover property (toggle_ok && act_a == ACT_TOGGLE && match_a);
endmodule : tpwm_timer

/* File: sim/tb_tpwm_timer.sv */
// testbench: pwm timer driven over apb, pin waveforms measured
`timescale 1ns/100ps
module tb_tpwm_timer import tpwm_pkg::*; ;
    logic        clk = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, rd, prdata;
    logic        pready, pslverr, er, pin_a_out, pin_a_oe, pin_b_out, pin_b_oe;
    int          fails = 0, tests_run = 0, cyc = 0;
    // four-state counts, so an unknown pin level cannot pass as zero
    logic [31:0] hi, rs;

    // 200 MHz clock
    always #2.5 clk = ~clk;

    tpwm_timer tpwm_timer_i (.clk(clk), .rstn(rstn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .pin_a_out(pin_a_out), .pin_a_oe(pin_a_oe),
        .pin_b_out(pin_b_out), .pin_b_oe(pin_b_oe));

    // hang guard: the whole run needs only a few thousand cycles
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fails++;
            end_sim();
        end
    end

    task automatic end_sim;
        $display("counts: tests_run=%0d fails=%0d", tests_run, fails);
        if (fails == 0 && tests_run > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : end_sim

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // one apb transfer; an idle edge first so psel is never assigned twice in a step
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask : rchk

    // counts high cycles and rising edges of pin a; window is whole periods
    task automatic win(input int n);
        logic p;
        hi = 0;
        rs = 0;
        @(posedge clk);
        p = pin_a_out;
        repeat (n) begin
            @(posedge clk);
            hi += pin_a_out;
            rs += (pin_a_out & !p);
            p = pin_a_out;
        end
    endtask : win

    // stop, zero the counter, load top and compare, then start; top below count would wrap
    task automatic run(input logic [3:0] m, input logic [1:0] a, input logic [2:0] s,
                       input logic [15:0] t, input logic [15:0] c, input int n, eh, er2);
        apb(1'b1, ADDR_CTRL, 32'h0);
        apb(1'b1, ADDR_CNT, 32'h0);
        apb(1'b1, ADDR_CAPTOP, {16'h0, t});
        apb(1'b1, ADDR_CMPA, {16'h0, c});
        apb(1'b1, ADDR_CTRL, {19'h0, 2'h3, s, 2'h0, a, m});
        repeat (40) @(posedge clk);
        // channel B has no action, so its level keeps its reset value
        chk({pin_a_oe, pin_b_oe, pin_b_out}, 32'h6);
        win(n);
        chk(hi, eh);
        chk(rs, er2);
        $display("test done: mode %h action %h", m, a);
    endtask : run

    // main sequence
    initial begin
        repeat (10) @(posedge clk);
        rstn <= 1'b1;
        rchk(ADDR_CTRL, 32'h0);
        rchk(ADDR_FLAGS, 32'h0);
        apb(1'b0, 8'h40, 32'h0);
        chk(er, 32'h1);
        apb(1'b1, ADDR_CTRL, 32'h5);
        apb(1'b1, ADDR_CMPA, 32'h1234);
        rchk(ADDR_CMPA, 32'h34);
        $display("test done: registers");
        run(MODE_FP_CAP, 2'h2, 3'h1, 16'h7, 16'h1, 56, 14, 7);
        rchk(ADDR_FLAGS, 32'hF);
        apb(1'b1, ADDR_CTRL, 32'h0);
        apb(1'b1, ADDR_FLAGS, 32'hF);
        rchk(ADDR_FLAGS, 32'h0);
        run(MODE_FP_CAP, 2'h3, 3'h1, 16'h7, 16'h1, 56, 42, 7);
        run(MODE_FP_CAP, 2'h2, 3'h1, 16'h7, 16'h0, 56, 7, 7);
        run(MODE_FP_CAP, 2'h2, 3'h1, 16'h7, 16'h7, 56, 56, 0);
        run(MODE_FP_CMPA, 2'h1, 3'h1, 16'h3, 16'h3, 56, 28, 7);
        run(MODE_FP_CAP, 2'h2, 3'h2, 16'h7, 16'h1, 448, 112, 7);
        run(MODE_PC_CAP, 2'h2, 3'h1, 16'h7, 16'h3, 56, 24, 4);
        run(MODE_PC_CAP, 2'h3, 3'h1, 16'h7, 16'h3, 56, 32, 4);
        run(MODE_PC_CAP, 2'h2, 3'h1, 16'h7, 16'h0, 56, 0, 0);
        run(MODE_PC_CAP, 2'h2, 3'h1, 16'h7, 16'h7, 56, 56, 0);
        run(MODE_PC_CMPA, 2'h1, 3'h1, 16'h7, 16'h7, 56, 28, 2);
        run(MODE_PC8, 2'h2, 3'h1, 16'h0, 16'h10, 510, 32, 1);
        run(MODE_FP8, 2'h2, 3'h1, 16'h0, 16'h10, 256, 17, 1);
        // stop, then park the counter above top so it must wrap through max first
        apb(1'b1, ADDR_CTRL, 32'h0);
        apb(1'b1, ADDR_CMPA, 32'h1);
        apb(1'b1, ADDR_CAPTOP, 32'h7);
        apb(1'b1, ADDR_CNT, 32'hFFFE);
        apb(1'b1, ADDR_CTRL, 32'h12E);
        repeat (4) @(posedge clk);
        chk({pin_a_oe, pin_a_out}, 32'h0);
        apb(1'b1, ADDR_CTRL, 32'h00E);
        apb(1'b1, ADDR_CNT, 32'h5);
        repeat (20) @(posedge clk);
        rchk(ADDR_CNT, 32'h5);
        $display("test done: pin direction and stopped clock");
        end_sim();
    end
endmodule : tb_tpwm_timer
